// [logic/wecs_top.v]
// Wake-up and diagnostic event capture, receive-pin alert and sleep guard
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wecs_consts.vh"

// Summary of operation
// - Enabled events set their status flag; disabled events leave it alone.
// - Power-on, watchdog failure and frame-error events are always captured.
// - All other events have an enable bit, cleared after power-on.
// - CAN wake and both wake pin edges are regular; the rest diagnostic.
// - Receive pin pulled low on pending event when offline in Normal/Standby.
// - Captured event in Sleep turns regulator on, Reset then Standby.
// - Global summary shows which group register holds a pending flag.
// - Writing one clears a flag, zero leaves it; many per write.
// - Any flag clear releases the receive pin and starts delay timer.
// - Events still set flags during delay; pin low again at expiry.
// - If all flags cleared before expiry, pin stays high.
// - Status readable at any time, also while timer runs.
// - Delay timer stops at once on reset pin falling edge.
// - Reset pin low in Reset, Sleep, Overtemperature and Off modes.
// - Pending event is signalled on receive pin while in Sleep.
// - Sleep is left only on a captured event of any kind or on overtemperature shutdown.
// - Sleep request with all regular wake events disabled forces reset.
// - Sleep command with any flag pending goes straight to Reset.
// - Sleep-disable bit set: Sleep command raises serial failure only.
// - Wake pin rising/falling transitions make events per their enables.
// - Summary bits 3..0: wake pin, transceiver, supply, system groups.
module wecs_top #(
  parameter [15:0] EVT_DELAY_CYC = `WECS_EVT_DELAY_CYC
) (
  input  wire        clock_i,
  input  wire        nrst_i,
  // Register port
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wr_data_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rd_data_o,
  // Event sources, one-cycle pulses on this clock
  input  wire        can_wake_event_i,
  input  wire        power_on_event_i,
  input  wire        overtemp_warning_event_i,
  input  wire        serial_failure_event_i,
  input  wire        watchdog_failure_event_i,
  input  wire        aux_supply_overvoltage_event_i,
  input  wire        aux_supply_undervoltage_event_i,
  input  wire        main_supply_undervoltage_event_i,
  input  wire        partial_net_frame_error_event_i,
  input  wire        bus_silence_event_i,
  input  wire        transceiver_failure_event_i,
  // Asynchronous wake pin level
  input  wire        wake_pin_i,
  // Surroundings
  input  wire        transceiver_offline_i,
  input  wire        overtemp_shutdown_i,
  // Outputs
  output wire        rxd_force_low_o,
  output wire        main_regulator_output_o,
  output wire        reset_output_pin_o,
  output wire [2:0]  mode_o
);

  // ========================================================
  // Operating modes
  localparam [2:0] MODE_OFF     = 3'h0;
  localparam [2:0] MODE_RESET   = 3'h1;
  localparam [2:0] MODE_STANDBY = 3'h2;
  localparam [2:0] MODE_NORMAL  = 3'h3;
  localparam [2:0] MODE_SLEEP   = 3'h4;
  localparam [2:0] MODE_OVTEMP  = 3'h5;
  // Off lasts one edge after reset release; the reset pulse follows.
  // Codes are private to this block but shown on mode_o as they are.

  reg  [2:0]  mode_reg;
  reg  [2:0]  mode_next;
  reg  [7:0]  rst_cnt_reg;
  reg  [7:0]  rst_cnt_next;
  reg  [31:0] flag_reg;
  wire [31:0] flag_next;
  reg  [7:0]  sys_en_reg;
  reg  [7:0]  sup_en_reg;
  reg  [7:0]  trx_en_reg;
  reg  [7:0]  wak_en_reg;
  reg         slpdis_reg;
  reg  [15:0] tmr_reg;
  reg         rstpin_prev_reg;
  reg         wake_s1_reg;
  reg         wake_s2_reg;
  reg         wake_s3_reg;
  // Raised for one cycle by a refused mode command; feeds the serial
  // failure flag like an external event would
  reg         bad_cmd;

  // ========================================================
  // Wake pin synchroniser and edge detect
  // Only the second and third stages feed logic; the first may still be settling.
  // Both history stages reset low, the level of an unused, grounded pin,
  // so no false edge follows reset.
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_s3_reg <= 1'b0;
    end else begin
      wake_s1_reg <= wake_pin_i;
      wake_s2_reg <= wake_s1_reg;
      wake_s3_reg <= wake_s2_reg;
    end
  end

  wire wake_rise = wake_s2_reg & ~wake_s3_reg;
  wire wake_fall = ~wake_s2_reg & wake_s3_reg;

  // ========================================================
  // Event and enable vectors, four status bytes side by side
  // Byte order: system, supply, transceiver, wake pin
  // Reserved positions are tied to zero so those flags can never set
  wire [7:0] sys_evt = {3'h0, power_on_event_i, 1'b0,
                        overtemp_warning_event_i,
                        serial_failure_event_i | bad_cmd,
                        watchdog_failure_event_i};
  wire [7:0] sup_evt = {5'h00, aux_supply_overvoltage_event_i,
                        aux_supply_undervoltage_event_i,
                        main_supply_undervoltage_event_i};
  wire [7:0] trx_evt = {2'h0, partial_net_frame_error_event_i,
                        bus_silence_event_i, 2'h0,
                        transceiver_failure_event_i, can_wake_event_i};
  wire [7:0] wak_evt = {6'h00, wake_rise, wake_fall};
  wire [31:0] evt_vec = {wak_evt, trx_evt, sup_evt, sys_evt};

  // Always-on bits bypass the software enables
  wire [31:0] en_vec = {wak_en_reg,
                        trx_en_reg | `WECS_TRX_ALWAYS,
                        sup_en_reg,
                        sys_en_reg | `WECS_SYS_ALWAYS};
  wire [31:0] valid_vec = {`WECS_WAK_MASK, `WECS_TRX_MASK,
                           `WECS_SUP_MASK, `WECS_SYS_MASK};

  // ========================================================
  // Write-one-to-clear decode per status byte
  wire wr_sys = wr_i & (addr_i == `WECS_ADDR_SYS);
  wire wr_sup = wr_i & (addr_i == `WECS_ADDR_SUP);
  wire wr_trx = wr_i & (addr_i == `WECS_ADDR_TRX);
  wire wr_wak = wr_i & (addr_i == `WECS_ADDR_WAK);
  wire [31:0] clr_vec = {{8{wr_wak}} & wr_data_i,
                         {8{wr_trx}} & wr_data_i,
                         {8{wr_sup}} & wr_data_i,
                         {8{wr_sys}} & wr_data_i};
  // A clear counts only where a one hits a flag that is set
  // A write of one to a flag that is already clear must not restart the
  // timer, or a polling host could keep the alert held off for ever
  wire any_clear = |(clr_vec & flag_reg & valid_vec);

  // Per-flag next state; a set in the clear cycle wins
  // so an event that lands with the host's clear is never lost
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_flag
      assign flag_next[gi] = valid_vec[gi] &
        ((evt_vec[gi] & en_vec[gi]) |
         (flag_reg[gi] & ~clr_vec[gi]));
    end
  endgenerate

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_reg <= 32'h0000_0000;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ========================================================
  // Group summary, bit per status register
  wire [3:0] group_pend = {|flag_reg[31:24], |flag_reg[23:16],
                           |flag_reg[15:8],  |flag_reg[7:0]};
  wire pending = |group_pend;
  // Regular wake sources: CAN wake, wake pin rising and falling
  // With none of them enabled, Sleep would be a dead end
  wire reg_wake_en = trx_en_reg[`WECS_TRX_CANWAKE] |
                     wak_en_reg[`WECS_WAK_RISE] |
                     wak_en_reg[`WECS_WAK_FALL];

  // ========================================================
  // Enable and configuration registers
  // Always-on enable positions are masked off here and read back as
  // zero; the capture path ORs them in instead
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sys_en_reg <= `WECS_EN_RST;
      sup_en_reg <= `WECS_EN_RST;
      trx_en_reg <= `WECS_EN_RST;
      wak_en_reg <= `WECS_EN_RST;
      slpdis_reg <= `WECS_SLPDIS_RST;
    end else if (wr_i) begin
      case (addr_i)
        `WECS_ADDR_SYS_EN: begin
          sys_en_reg <= wr_data_i & `WECS_SYS_MASK & ~`WECS_SYS_ALWAYS;
        end
        `WECS_ADDR_SUP_EN: begin
          sup_en_reg <= wr_data_i & `WECS_SUP_MASK;
        end
        `WECS_ADDR_TRX_EN: begin
          trx_en_reg <= wr_data_i & `WECS_TRX_MASK & ~`WECS_TRX_ALWAYS;
        end
        `WECS_ADDR_WAK_EN: begin
          wak_en_reg <= wr_data_i & `WECS_WAK_MASK;
        end
        `WECS_ADDR_CFG: begin
          slpdis_reg <= wr_data_i[`WECS_CFG_SLPDIS];
        end
        default: begin
          slpdis_reg <= slpdis_reg;
        end
      endcase
    end
  end

  // ========================================================
  // Mode sequencing, including the sleep entry guard
  // Sleep guard order: disable bit first, then a pending flag or no
  // regular wake source, then Sleep. A refused Sleep must never leave
  // the host unpowered with no way back.
  wire mode_wr = wr_i & (addr_i == `WECS_ADDR_MODE);
  wire [2:0] mode_cmd = wr_data_i[2:0];

  always @* begin
    mode_next    = mode_reg;
    rst_cnt_next = rst_cnt_reg;
    bad_cmd      = 1'b0;
    case (mode_reg)
      MODE_OFF: begin
        mode_next    = MODE_RESET;
        rst_cnt_next = `WECS_RESET_CYC;
      end
      MODE_RESET: begin
        if (rst_cnt_reg == 8'h00) begin
          mode_next = MODE_STANDBY;
        end else begin
          rst_cnt_next = rst_cnt_reg - 8'h01;
        end
      end
      MODE_STANDBY, MODE_NORMAL: begin
        if (mode_wr) begin
          if (mode_cmd == `WECS_CMD_SLEEP) begin
            if (slpdis_reg) begin
              bad_cmd = 1'b1;
            end else if (pending || !reg_wake_en) begin
              mode_next    = MODE_RESET;
              rst_cnt_next = `WECS_RESET_CYC;
            end else begin
              mode_next = MODE_SLEEP;
            end
          end else if (mode_cmd == `WECS_CMD_STANDBY) begin
            mode_next = MODE_STANDBY;
          end else if (mode_cmd == `WECS_CMD_NORMAL) begin
            mode_next = MODE_NORMAL;
          end else begin
            bad_cmd = 1'b1;               // Illegal mode code
          end
        end
      end
      MODE_SLEEP: begin
        // Only a captured event wakes; mode register writes are ignored
        // Any captured flag wakes, diagnostic ones included, since only
        // enabled or always-on events can set one
        if (pending) begin
          mode_next    = MODE_RESET;
          rst_cnt_next = `WECS_RESET_CYC;
        end
      end
      MODE_OVTEMP: begin
        if (!overtemp_shutdown_i) begin
          mode_next    = MODE_RESET;
          rst_cnt_next = `WECS_RESET_CYC;
        end
      end
      default: begin
        mode_next = MODE_OFF;
      end
    endcase
    // Overtemperature shutdown overrides every mode but Off
    if (overtemp_shutdown_i && mode_reg != MODE_OFF) begin
      mode_next = MODE_OVTEMP;
    end
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg    <= MODE_OFF;
      rst_cnt_reg <= 8'h00;
    end else begin
      mode_reg    <= mode_next;
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  // ========================================================
  // Reset pin and regulator
  // Both decode the mode register only, so they never glitch on a write
  assign reset_output_pin_o = (mode_reg == MODE_STANDBY) ||
                              (mode_reg == MODE_NORMAL);
  // Regulator off only while asleep or before power-up
  assign main_regulator_output_o = (mode_reg != MODE_SLEEP) &&
                                   (mode_reg != MODE_OFF);
  assign mode_o = mode_reg;

  // ========================================================
  // Event delay timer
  // A reset pin fall zeroes the count, so the alert path starts clean
  // when the host comes back out of Reset
  wire rstpin_fall = rstpin_prev_reg & ~reset_output_pin_o;

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rstpin_prev_reg <= 1'b0;
      tmr_reg         <= 16'h0000;
    end else begin
      rstpin_prev_reg <= reset_output_pin_o;
      if (rstpin_fall) begin
        tmr_reg <= 16'h0000;
      end else if (any_clear) begin
        tmr_reg <= EVT_DELAY_CYC;
      end else if (tmr_reg != 16'h0000) begin
        tmr_reg <= tmr_reg - 16'h0001;
      end
    end
  end

  wire tmr_run = (tmr_reg != 16'h0000);

  // ========================================================
  // Receive pin alert; released during the delay, also on the clear cycle
  // The drop on the clear cycle is combinational so the pin rises with
  // the write itself; the cost is a path from the write strobe to a pin
  wire alert_mode = (transceiver_offline_i &&
                     (mode_reg == MODE_STANDBY ||
                      mode_reg == MODE_NORMAL)) ||
                    (mode_reg == MODE_SLEEP);
  assign rxd_force_low_o = pending & alert_mode & ~tmr_run &
                           ~any_clear;

  // ========================================================
  // Read port, data valid the cycle after the strobe
  // Zero outside the answer cycle keeps a shared read bus clean
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `WECS_ADDR_GLOBAL: rd_data_o <= {4'h0, group_pend};
        `WECS_ADDR_SYS:    rd_data_o <= flag_reg[7:0];
        `WECS_ADDR_SUP:    rd_data_o <= flag_reg[15:8];
        `WECS_ADDR_TRX:    rd_data_o <= flag_reg[23:16];
        `WECS_ADDR_WAK:    rd_data_o <= flag_reg[31:24];
        `WECS_ADDR_SYS_EN: rd_data_o <= sys_en_reg;
        `WECS_ADDR_SUP_EN: rd_data_o <= sup_en_reg;
        `WECS_ADDR_TRX_EN: rd_data_o <= trx_en_reg;
        `WECS_ADDR_WAK_EN: rd_data_o <= wak_en_reg;
        `WECS_ADDR_MODE:   rd_data_o <= {5'h00, mode_reg};
        `WECS_ADDR_CFG:    rd_data_o <= {7'h00, slpdis_reg};
        default:           rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end

endmodule // wecs_top
`default_nettype wire

// [logic/wecs_consts.vh]
// Constants of the wake and event capture block: offsets, fields, timing
`ifndef WECS_CONSTS_VH
`define WECS_CONSTS_VH

// ==========================================================
// Register offsets (8-bit address space)
`define WECS_ADDR_GLOBAL   8'h60
`define WECS_ADDR_SYS      8'h61
`define WECS_ADDR_SUP      8'h62
`define WECS_ADDR_TRX      8'h63
`define WECS_ADDR_WAK      8'h64
`define WECS_ADDR_SYS_EN   8'h70
`define WECS_ADDR_SUP_EN   8'h71
`define WECS_ADDR_TRX_EN   8'h72
`define WECS_ADDR_WAK_EN   8'h73
`define WECS_ADDR_MODE     8'h74
`define WECS_ADDR_CFG      8'h75

// ==========================================================
// Implemented flag bits per status register
`define WECS_SYS_MASK      8'h17
`define WECS_SUP_MASK      8'h07
`define WECS_TRX_MASK      8'h33
`define WECS_WAK_MASK      8'h03
// Flags captured with no enable (power-on, watchdog, frame error)
`define WECS_SYS_ALWAYS    8'h11
`define WECS_TRX_ALWAYS    8'h20
// Field positions
`define WECS_SYS_PWRON     4
`define WECS_SYS_OVTWARN   2
`define WECS_SYS_SERFAIL   1
`define WECS_SYS_WDOGFAIL  0
`define WECS_TRX_FRMERR    5
`define WECS_TRX_SILENCE   4
`define WECS_TRX_FAIL      1
`define WECS_TRX_CANWAKE   0
`define WECS_WAK_RISE      1
`define WECS_WAK_FALL      0
`define WECS_CFG_SLPDIS    0

// ==========================================================
// Reset values
`define WECS_EN_RST        8'h00
`define WECS_SLPDIS_RST    1'b0

// ==========================================================
// Mode control field codes
`define WECS_CMD_SLEEP     3'h1
`define WECS_CMD_STANDBY   3'h4
`define WECS_CMD_NORMAL    3'h7

// ==========================================================
// Timing in clock cycles (10 MHz clock)
`define WECS_EVT_DELAY_CYC 16'd100
`define WECS_RESET_CYC     8'd20

`endif

// [tb/wecs_checker_assertions.sv]
// Port-level checker for the event capture and sleep guard block
`timescale 1ns/1ps
`default_nettype none
module wecs_checker #(
  parameter [15:0] EVT_DELAY_CYC = 16'd100
) (
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       power_on_event_i,
  input wire logic       watchdog_failure_event_i,
  input wire logic       transceiver_offline_i,
  input wire logic       rxd_force_low_o,
  input wire logic       main_regulator_output_o,
  input wire logic       reset_output_pin_o,
  input wire logic [2:0] mode_o
);
  // ==========================================================
  // One clock domain, so clocking and disable are shared
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Standby or Normal, the only modes with the reset pin high
  wire logic up = (mode_o == 3'd2) || (mode_o == 3'd3);

  // ==========================================================
  // Register port and capture
  read_idle_zero_a: assert property (
    !rd_i |=> rd_data_o == 8'h00)
    else $error("read data not zero outside a read answer");
  pwron_capture_a: assert property (
    power_on_event_i ##1 (rd_i && addr_i == 8'h61) |=> rd_data_o[4])
    else $error("power-on event not captured");
  wdog_capture_a: assert property (
    watchdog_failure_event_i ##1 (rd_i && addr_i == 8'h61) |=> rd_data_o[0])
    else $error("watchdog not captured");
  global_sys_a: assert property (
    power_on_event_i ##1 (rd_i && addr_i == 8'h60) |=> rd_data_o[0])
    else $error("summary misses system group");
  global_top_a: assert property (
    rd_i && addr_i == 8'h60 |=> rd_data_o[7:4] == 4'h0)
    else $error("summary upper bits not zero");

  // ==========================================================
  // Receive pin, reset pin and mode sequencing
  reset_pin_mode_a: assert property (
    reset_output_pin_o == up)
    else $error("reset pin level does not match mode");
  rxd_allowed_a: assert property (
    rxd_force_low_o |-> mode_o == 3'h4 || (up && transceiver_offline_i))
    else $error("rxd low when not allowed");
  rxd_delay_a: assert property (
    $fell(rxd_force_low_o) && wr_i |=> !rxd_force_low_o[*3])
    else $error("rxd low again inside event delay");
  sleep_exit_a: assert property (
    $past(mode_o) == 3'h4 && mode_o != 3'h4 |-> mode_o == 3'h1)
    else $error("sleep left other than into reset");
  wake_standby_a: assert property (
    $past(mode_o) == 3'h4 && mode_o == 3'h1
    |-> ##[1:30] (mode_o == 3'h2 && main_regulator_output_o))
    else $error("wake from sleep did not reach standby");
endmodule // wecs_checker

bind wecs_top wecs_checker #(.EVT_DELAY_CYC(EVT_DELAY_CYC)) wecs_checker_i (
  .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .rd_data_o(rd_data_o), .power_on_event_i(power_on_event_i),
  .watchdog_failure_event_i(watchdog_failure_event_i),
  .transceiver_offline_i(transceiver_offline_i),
  .rxd_force_low_o(rxd_force_low_o),
  .main_regulator_output_o(main_regulator_output_o),
  .reset_output_pin_o(reset_output_pin_o), .mode_o(mode_o));
`default_nettype wire

// [tb/wecs_rxd_pin.sv]
// Receive pin as the host sees it: pulled up unless the block pulls low
`timescale 1ns/1ps
`default_nettype none
module wecs_rxd_pin (
  input  wire logic force_low_i,
  output wire logic level_o
);
  // ==========================================================
  // Pull-up wins whenever the block lets go of the pin
  assign level_o = force_low_i ? 1'b0 : 1'b1;
endmodule // wecs_rxd_pin
`default_nettype wire

// [tb/test_wecs_top.sv]
// Self-checking bench for the event capture and sleep guard block
`timescale 1ns/1ps
`default_nettype none
module test_wecs_top;
  // ==========================================================
  // Stimulus and observed signals
  logic        clock_i, nrst_i, wr_i, rd_i, wake_pin_i, offline, hot;
  logic [7:0]  addr_i, wr_data_i;
  logic [10:0] ev;
  wire  [7:0]  rd_data_o;
  wire  [2:0]  mode_o;
  wire         rxd_low, reg_on, rst_pin, rxd_pin;
  int          fail_count = 0;
  int          compares = 0;

  // Short delay keeps the alert hold-off visible in few cycles
  wecs_top #(.EVT_DELAY_CYC(16'd5)) wecs_top_i (
    .clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .can_wake_event_i(ev[0]), .power_on_event_i(ev[1]),
    .overtemp_warning_event_i(ev[2]), .serial_failure_event_i(ev[3]),
    .watchdog_failure_event_i(ev[4]),
    .aux_supply_overvoltage_event_i(ev[5]),
    .aux_supply_undervoltage_event_i(ev[6]),
    .main_supply_undervoltage_event_i(ev[7]),
    .partial_net_frame_error_event_i(ev[8]),
    .bus_silence_event_i(ev[9]), .transceiver_failure_event_i(ev[10]),
    .wake_pin_i(wake_pin_i), .transceiver_offline_i(offline),
    .overtemp_shutdown_i(hot), .rxd_force_low_o(rxd_low),
    .main_regulator_output_o(reg_on), .reset_output_pin_o(rst_pin),
    .mode_o(mode_o));
  wecs_rxd_pin wecs_rxd_pin_i (.force_low_i(rxd_low), .level_o(rxd_pin));

  // 10 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // ==========================================================
  // Access tasks
  task automatic summarize;
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // Pulses events m, reads a on the very next cycle, expects e
  task automatic rd(input logic [10:0] m, input logic [7:0] a,
                    input logic [7:0] e);
    @(posedge clock_i);
    ev <= m;
    @(posedge clock_i);
    ev <= 11'h000;
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk($sformatf("reg %h", a), e, rd_data_o);
  endtask
  task automatic pin(input logic e);
    @(negedge clock_i);
    chk("rxd pin", {7'h00, e}, {7'h00, rxd_pin});
  endtask
  // Bounded wait for a mode; a miss ends the run
  task automatic wm(input logic [2:0] m);
    int k;
    for (k = 0; k < 60 && mode_o !== m; k++)
      @(negedge clock_i);
    chk("mode", {5'h00, m}, {5'h00, mode_o});
    if (mode_o !== m)
      summarize();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    int k;
    nrst_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wr_data_i = 8'h00;
    ev = 11'h000;
    wake_pin_i = 1'b0;
    offline = 1'b0;
    hot = 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    wm(3'h2);
    chk("reset pin", 8'h01, {7'h00, rst_pin});
    // Enables start clear; the mode register shows Standby
    for (k = 0; k < 6; k++)
      rd(11'h000, 8'h70 + k[7:0], (k == 4) ? 8'h02 : 8'h00);
    // Everything fires while masked: only the fixed three land
    rd(11'h7ff, 8'h61, 8'h11);
    rd(11'h000, 8'h62, 8'h00);
    rd(11'h000, 8'h63, 8'h20);
    rd(11'h012, 8'h60, 8'h05);
    wr(8'h61, 8'h11);
    wr(8'h63, 8'h20);
    rd(11'h000, 8'h60, 8'h00);
    wr(8'h70, 8'h06);
    wr(8'h71, 8'h07);
    wr(8'h72, 8'h13);
    wr(8'h73, 8'h03);
    @(posedge clock_i);
    wake_pin_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    wake_pin_i <= 1'b0;
    rd(11'h7ff, 8'h61, 8'h17);
    rd(11'h000, 8'h62, 8'h07);
    rd(11'h000, 8'h63, 8'h33);
    rd(11'h000, 8'h64, 8'h03);
    rd(11'h000, 8'h60, 8'h0f);
    wr(8'h61, 8'h05);
    rd(11'h000, 8'h61, 8'h12);
    wr(8'h61, 8'h12);
    wr(8'h62, 8'h07);
    wr(8'h63, 8'h33);
    wr(8'h64, 8'h03);
    rd(11'h000, 8'h60, 8'h00);
    // Offline transceiver: alert, release, hold-off, re-alert
    @(posedge clock_i);
    offline <= 1'b1;
    repeat (8) @(posedge clock_i);
    rd(11'h001, 8'h63, 8'h01);
    pin(1'b0);
    wr(8'h63, 8'h01);
    pin(1'b1);
    rd(11'h200, 8'h63, 8'h10);
    pin(1'b1);
    for (k = 0; k < 10 && rxd_pin !== 1'b0; k++)
      @(negedge clock_i);
    pin(1'b0);
    if (rxd_pin !== 1'b0)
      summarize();
    wr(8'h63, 8'h10);
    rd(11'h001, 8'h63, 8'h01);
    wr(8'h63, 8'h01);
    repeat (8) @(posedge clock_i);
    pin(1'b1);
    @(posedge clock_i);
    offline <= 1'b0;
    rd(11'h001, 8'h63, 8'h01);
    pin(1'b1);
    wr(8'h63, 8'h01);
    // Sleep request with a flag pending goes to reset
    rd(11'h004, 8'h61, 8'h04);
    wr(8'h74, 8'h01);
    @(negedge clock_i);
    chk("mode", 8'h01, {5'h00, mode_o});
    chk("reset pin", 8'h00, {7'h00, rst_pin});
    wm(3'h2);
    wr(8'h61, 8'h04);
    // Sleep disabled, then Normal, illegal code 2 and Standby
    wr(8'h75, 8'h01);
    wr(8'h74, 8'h01);
    rd(11'h000, 8'h74, 8'h02);
    rd(11'h000, 8'h61, 8'h02);
    wr(8'h61, 8'h02);
    wr(8'h75, 8'h00);
    wr(8'h74, 8'h07);
    wr(8'h74, 8'h02);
    rd(11'h000, 8'h74, 8'h03);
    rd(11'h000, 8'h61, 8'h02);
    wr(8'h61, 8'h02);
    wr(8'h74, 8'h04);
    // No regular wake source enabled: reset instead of sleep
    wr(8'h72, 8'h12);
    wr(8'h73, 8'h00);
    wr(8'h74, 8'h01);
    @(negedge clock_i);
    chk("mode", 8'h01, {5'h00, mode_o});
    wm(3'h2);
    wr(8'h73, 8'h02);
    // Sleep with rising wake only; masked CAN wake must not wake
    wr(8'h74, 8'h01);
    @(negedge clock_i);
    chk("mode", 8'h04, {5'h00, mode_o});
    chk("regulator", 8'h00, {7'h00, reg_on});
    rd(11'h001, 8'h63, 8'h00);
    chk("mode", 8'h04, {5'h00, mode_o});
    @(posedge clock_i);
    wake_pin_i <= 1'b1;
    wm(3'h1);
    wm(3'h2);
    chk("regulator", 8'h01, {7'h00, reg_on});
    rd(11'h000, 8'h64, 8'h02);
    wr(8'h64, 8'h02);
    // Overtemperature shutdown holds the reset pin low until it ends
    @(posedge clock_i);
    hot <= 1'b1;
    wm(3'h5);
    chk("reset pin", 8'h00, {7'h00, rst_pin});
    @(posedge clock_i);
    hot <= 1'b0;
    wm(3'h2);
    chk("reset pin", 8'h01, {7'h00, rst_pin});
    summarize();
  end
endmodule // test_wecs_top
`default_nettype wire
